/* logic/pbmc_pkg.sv */
// Constants and types shared by the loop bandwidth control block.
package pbmc_pkg;
	// Register byte offsets on the Wishbone slave.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FBMUL  = 8'h08;
	localparam logic [7:0] OFS_REFDIV = 8'h0C;
	localparam logic [7:0] OFS_VRANGE = 8'h10;

	// Field widths of the divider, range and control registers.
	localparam int N_W = 12;
	localparam int R_W = 4;
	localparam int L_W = 8;
	localparam int CTRL_W = 10;

	// Status register bit positions.
	localparam int ST_LOCK  = 0;
	localparam int ST_TRACK = 1;
	localparam int ST_BASE  = 2;

	// Reset values of the divider and range registers.
	localparam logic [N_W-1:0] FBMUL_RST  = 12'h001;
	localparam logic [R_W-1:0] REFDIV_RST = 4'h1;
	localparam logic [L_W-1:0] VRANGE_RST = 8'h80;

	// Lock detector window and tolerances, in reference periods.
	localparam int WIN_PER  = 16;
	localparam int PULL_TOL = 4;
	localparam int LOCK_TOL = 1;

	// Selected clock edges per bus clock period.
	localparam int BUS_DIV = 4;

	// Control register layout, most significant field first.
	typedef struct packed {
		logic [1:0] range_exp;
		logic       rsvd;
		logic [1:0] prescale;
		logic       track;
		logic       irq_en;
		logic       base_sel;
		logic       power_on;
		logic       auto_bw;
	} pbmc_ctrl_s;

	localparam pbmc_ctrl_s CTRL_RST = '0;

	// Lock detector activity.
	typedef enum logic [0:0] {
		DET_OFF,
		DET_RUN
	} pbmc_det_e;
endpackage

/* logic/pbmc_top.sv */
// Loop bandwidth, lock detect and base clock control with Wishbone slave.
// Functional notes
// - Track flag stays zero while the filter is in acquisition.
// - Filter runs in tracking whenever not acquiring or track flag set.
// - With auto bandwidth on, the lock detector switches filter mode itself.
// - In auto mode the track flag is read-only and shows filter mode.
// - Auto mode sets track flag inside acquisition tolerance, clears outside.
// - Auto mode locked flag is read-only, set inside lock tolerance.
// - With irq enable in auto mode, each locked flag change requests interrupt.
// - In manual mode the track flag is a writable filter mode control.
// - Manual mode disables the locked flag and all interrupt requests.
// - Loop locks at reference over R, times N, times two to P.
// - Bus clock runs at a quarter of the selected clock.
// - A zero reference divider or multiplier acts as one.
// - Vco base clock selection is refused while the loop is off.
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module pbmc_top
	import pbmc_pkg::*;
#(
	parameter int WIN    = WIN_PER,
	parameter int PULL_T = PULL_TOL,
	parameter int LOCK_T = LOCK_TOL
) (
	input  wire logic           ref_clk,
	input  wire logic           rst,
	input  wire logic           wb_cyc,
	input  wire logic           wb_stb,
	input  wire logic           wb_we,
	input  wire logic [7:0]     wb_adr,
	input  wire logic [3:0]     wb_sel,
	input  wire logic [31:0]    wb_dat_w,
	output logic      [31:0]    wb_dat_r,
	output logic                wb_ack,
	input  wire logic           vco_clock,
	output logic                loop_power_on,
	output logic                filter_track_flag,
	output logic                base_clock_select,
	output logic      [1:0]     prescale_exp,
	output logic      [1:0]     range_exp,
	output logic      [L_W-1:0] range_mult,
	output logic      [N_W-1:0] fb_mult,
	output logic      [R_W-1:0] ref_div,
	output logic                locked,
	output logic                lock_irq,
	output logic                bus_clk_en
);

	pbmc_ctrl_s     ctrl_ff;
	pbmc_ctrl_s     nxt_ctrl;
	pbmc_ctrl_s     ctrl_rd;
	pbmc_det_e      det_ff;
	logic [N_W-1:0] fb_ff;
	logic [R_W-1:0] rd_ff;
	logic [L_W-1:0] l_ff;
	logic [N_W-1:0] fb_eff_ff;
	logic [R_W-1:0] r_eff_ff;
	logic [31:0]    dat_ff;
	logic [31:0]    rd_mux;
	logic           ack_ff;
	logic           wb_req;
	logic           wb_wr;
	logic [15:0]    ctrl_wr;
	logic [15:0]    fb_wr;
	logic [15:0]    rd_wr;
	logic [15:0]    l_wr;
	logic           vco_s1_ff;
	logic           vco_s2_ff;
	logic           vco_s3_ff;
	logic           vco_edge;
	logic [2:0]     pre_cnt_ff;
	logic [2:0]     pre_top;
	logic           pre_last;
	logic [N_W-1:0] mod_cnt_ff;
	logic           vdv_ev;
	logic [R_W-1:0] r_cnt_ff;
	logic           rdv_ev;
	logic [7:0]     per_cnt_ff;
	logic [7:0]     hit_cnt_ff;
	logic [7:0]     hit_tot;
	logic [7:0]     err;
	logic           win_done;
	logic           pull_ok;
	logic           lock_ok;
	logic           track_ff;
	logic           lock_ff;
	logic           nxt_lock;
	logic           irq_ff;
	logic           base_ff;
	logic           sel_edge;
	logic [1:0]     bus_div_ff;
	logic           bus_en_ff;

	// Byte lanes 0 and 1 carry every register; upper lanes are ignored.
	function automatic logic [15:0] lane_wr(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0]  sel
	);
		lane_wr = old;
		if (sel[0]) begin
			lane_wr[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			lane_wr[15:8] = dat[15:8];
		end
	endfunction

	// A request is served once; ack drops in the cycle after it rose.
	assign wb_req  = wb_cyc & wb_stb & ~ack_ff;
	assign wb_wr   = wb_req & wb_we;
	assign ctrl_wr = lane_wr({6'h00, ctrl_ff}, wb_dat_w, wb_sel);
	assign fb_wr   = lane_wr({4'h0, fb_ff}, wb_dat_w, wb_sel);
	assign rd_wr   = lane_wr({12'h000, rd_ff}, wb_dat_w, wb_sel);
	assign l_wr    = lane_wr({8'h00, l_ff}, wb_dat_w, wb_sel);

	// Control write filtering; refusals keep the old field value.
	always_comb begin
		nxt_ctrl = pbmc_ctrl_s'(ctrl_wr[CTRL_W-1:0]);
		nxt_ctrl.rsvd = 1'b0;
		if (ctrl_ff.auto_bw) begin
			nxt_ctrl.track = ctrl_ff.track;
		end
		// The loop must not stop while it drives the base clock.
		if (ctrl_ff.base_sel) begin
			nxt_ctrl.power_on = 1'b1;
		end
		// Power and selection never change in the same write.
		if (nxt_ctrl.power_on != ctrl_ff.power_on) begin
			nxt_ctrl.base_sel = ctrl_ff.base_sel;
		end
		if (!nxt_ctrl.power_on) begin
			nxt_ctrl.base_sel = 1'b0;
		end
	end

	// Control register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
		end else if (wb_wr && wb_adr == OFS_CTRL) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Divider and range registers; values are stored as written.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fb_ff <= FBMUL_RST;
			rd_ff <= REFDIV_RST;
			l_ff  <= VRANGE_RST;
		end else if (wb_wr) begin
			if (wb_adr == OFS_FBMUL) begin
				fb_ff <= fb_wr[N_W-1:0];
			end
			if (wb_adr == OFS_REFDIV) begin
				rd_ff <= rd_wr[R_W-1:0];
			end
			if (wb_adr == OFS_VRANGE) begin
				l_ff <= l_wr[L_W-1:0];
			end
		end
	end

	// Zero divisors are meaningless, so they act as one.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fb_eff_ff <= FBMUL_RST;
			r_eff_ff  <= REFDIV_RST;
		end else begin
			fb_eff_ff <= (fb_ff == '0) ? N_W'(1) : fb_ff;
			r_eff_ff  <= (rd_ff == '0) ? R_W'(1) : rd_ff;
		end
	end

	// Read multiplexer; the track field shows the live filter mode.
	always_comb begin
		ctrl_rd = ctrl_ff;
		ctrl_rd.track = track_ff;
		rd_mux = 32'h0000_0000;
		case (wb_adr)
			OFS_CTRL: begin
				rd_mux[CTRL_W-1:0] = ctrl_rd;
			end
			OFS_STATUS: begin
				rd_mux[ST_LOCK]  = lock_ff;
				rd_mux[ST_TRACK] = track_ff;
				rd_mux[ST_BASE]  = base_ff;
			end
			OFS_FBMUL: begin
				rd_mux[N_W-1:0] = fb_ff;
			end
			OFS_REFDIV: begin
				rd_mux[R_W-1:0] = rd_ff;
			end
			OFS_VRANGE: begin
				rd_mux[L_W-1:0] = l_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Bus answer one cycle after the request; unmapped reads give zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_req;
			if (wb_req) begin
				dat_ff <= rd_mux;
			end
		end
	end

	// The vco pin is asynchronous; the edge is taken from the second and third stages.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			vco_s1_ff <= 1'b0;
			vco_s2_ff <= 1'b0;
			vco_s3_ff <= 1'b0;
		end else begin
			vco_s1_ff <= vco_clock;
			vco_s2_ff <= vco_s1_ff;
			vco_s3_ff <= vco_s2_ff;
		end
	end

	assign vco_edge = vco_s2_ff & ~vco_s3_ff;

	// Detector runs only while the loop is powered.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			det_ff <= DET_OFF;
		end else begin
			case (det_ff)
				DET_OFF: begin
					if (ctrl_ff.power_on) begin
						det_ff <= DET_RUN;
					end
				end
				DET_RUN: begin
					if (!ctrl_ff.power_on) begin
						det_ff <= DET_OFF;
					end
				end
				default: begin
					det_ff <= DET_OFF;
				end
			endcase
		end
	end

	// Feedback path divides vco edges by two to the P, then by N.
	assign pre_top  = (3'h1 << ctrl_ff.prescale) - 3'h1;
	assign pre_last = (pre_cnt_ff == pre_top);
	assign vdv_ev   = vco_edge & pre_last &
		(mod_cnt_ff == fb_eff_ff - N_W'(1));

	always_ff @(posedge ref_clk) begin
		if (rst || det_ff == DET_OFF) begin
			pre_cnt_ff <= 3'h0;
			mod_cnt_ff <= '0;
		end else if (vco_edge) begin
			if (pre_last) begin
				pre_cnt_ff <= 3'h0;
				if (vdv_ev) begin
					mod_cnt_ff <= '0;
				end else begin
					mod_cnt_ff <= mod_cnt_ff + N_W'(1);
				end
			end else begin
				pre_cnt_ff <= pre_cnt_ff + 3'h1;
			end
		end
	end

	// Reference path divides the reference clock by R.
	assign rdv_ev = (r_cnt_ff == r_eff_ff - R_W'(1));

	always_ff @(posedge ref_clk) begin
		if (rst || det_ff == DET_OFF || rdv_ev) begin
			r_cnt_ff <= '0;
		end else begin
			r_cnt_ff <= r_cnt_ff + R_W'(1);
		end
	end

	// Feedback events are counted over a whole number of reference periods.
	assign win_done = rdv_ev & (per_cnt_ff == 8'(WIN - 1));
	assign hit_tot  = hit_cnt_ff + {7'h00, vdv_ev};
	assign err      = (hit_tot >= 8'(WIN)) ? hit_tot - 8'(WIN)
		: 8'(WIN) - hit_tot;
	assign pull_ok  = (err <= 8'(PULL_T));
	assign lock_ok  = (err <= 8'(LOCK_T));

	always_ff @(posedge ref_clk) begin
		if (rst || det_ff == DET_OFF) begin
			per_cnt_ff <= 8'h00;
			hit_cnt_ff <= 8'h00;
		end else if (win_done) begin
			per_cnt_ff <= 8'h00;
			hit_cnt_ff <= 8'h00;
		end else begin
			if (rdv_ev) begin
				per_cnt_ff <= per_cnt_ff + 8'h01;
			end
			// Saturate so a runaway vco cannot wrap into a false lock.
			if (vdv_ev && hit_cnt_ff != 8'hFF) begin
				hit_cnt_ff <= hit_cnt_ff + 8'h01;
			end
		end
	end

	// Filter mode: low means acquisition, high means tracking.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			track_ff <= 1'b0;
		end else if (!ctrl_ff.auto_bw) begin
			track_ff <= ctrl_ff.track;
		end else if (!ctrl_ff.power_on) begin
			track_ff <= 1'b0;
		end else if (win_done) begin
			track_ff <= pull_ok;
		end
	end

	// Lock flag exists only in auto mode with the loop powered.
	always_comb begin
		nxt_lock = lock_ff;
		if (!ctrl_ff.auto_bw || !ctrl_ff.power_on) begin
			nxt_lock = 1'b0;
		end else if (win_done) begin
			nxt_lock = lock_ok;
		end
	end

	// A one-cycle request marks each lock change in either direction, except the drop on leaving auto mode.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lock_ff <= 1'b0;
			irq_ff  <= 1'b0;
		end else begin
			lock_ff <= nxt_lock;
			irq_ff  <= ctrl_ff.auto_bw & ctrl_ff.irq_en &
				(nxt_lock != lock_ff);
		end
	end

	// A zero range factor also forces the crystal clock.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			base_ff <= 1'b0;
		end else begin
			base_ff <= ctrl_ff.base_sel & ctrl_ff.power_on &
				(l_ff != '0);
		end
	end

	// Bus clock enable every fourth edge of the selected clock.
	assign sel_edge = base_ff ? vco_edge : 1'b1;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_div_ff <= 2'h0;
			bus_en_ff  <= 1'b0;
		end else begin
			bus_en_ff <= sel_edge & (bus_div_ff == 2'(BUS_DIV - 1));
			if (sel_edge) begin
				bus_div_ff <= bus_div_ff + 2'h1;
			end
		end
	end

	assign wb_dat_r          = dat_ff;
	assign wb_ack            = ack_ff;
	assign loop_power_on     = ctrl_ff.power_on;
	assign filter_track_flag = track_ff;
	assign base_clock_select = base_ff;
	assign prescale_exp      = ctrl_ff.prescale;
	assign range_exp         = ctrl_ff.range_exp;
	assign range_mult        = l_ff;
	assign fb_mult           = fb_eff_ff;
	assign ref_div           = r_eff_ff;
	assign locked            = lock_ff;
	assign lock_irq          = irq_ff;
	assign bus_clk_en        = bus_en_ff;

	// Checks on the behaviour above.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_track_idle_zero: assert property (
		ctrl_ff.auto_bw && !ctrl_ff.power_on |=> !track_ff)
		else $error("track flag set while loop is off in auto mode");
	chk_auto_track_follow: assert property (
		ctrl_ff.auto_bw && ctrl_ff.power_on && win_done
		|=> track_ff == $past(pull_ok))
		else $error("auto track flag does not follow detector");
	chk_track_read_only: assert property (
		ctrl_ff.auto_bw && wb_wr && wb_adr == OFS_CTRL
		|=> ctrl_ff.track == $past(ctrl_ff.track))
		else $error("track bit written in auto mode");
	chk_acq_clears_track: assert property (
		ctrl_ff.auto_bw && ctrl_ff.power_on && win_done && !pull_ok
		##1 ctrl_ff.auto_bw && ctrl_ff.power_on && !win_done
		|-> !track_ff)
		else $error("track flag kept outside acquisition tolerance");
	chk_lock_follow: assert property (
		ctrl_ff.auto_bw && ctrl_ff.power_on && win_done
		|=> lock_ff == $past(lock_ok))
		else $error("locked flag does not follow detector");
	chk_lock_change_irq: assert property (
		$changed(lock_ff) && $past(ctrl_ff.auto_bw && ctrl_ff.irq_en)
		|-> lock_irq)
		else $error("lock change without interrupt request");
	chk_manual_track: assert property (
		!ctrl_ff.auto_bw |=> track_ff == $past(ctrl_ff.track))
		else $error("manual track flag not applied");
	chk_manual_quiet: assert property (
		!ctrl_ff.auto_bw [*2] |-> !locked && !lock_irq)
		else $error("lock or interrupt active in manual mode");
	chk_zero_as_one: assert property (
		fb_ff == '0 |=> fb_mult == N_W'(1))
		else $error("zero multiplier not treated as one");
	chk_base_refused: assert property (
		!ctrl_ff.power_on |=> !base_clock_select)
		else $error("vco base clock selected with loop off");
	chk_bus_quarter: assert property (
		(bus_en_ff && !base_ff) ##1 (!base_ff && !bus_en_ff) [*3]
		|=> bus_en_ff)
		else $error("bus clock not a quarter of crystal clock");

	cov_lock_rise: cover property (!lock_ff ##1 lock_ff);
	cov_lock_irq: cover property (lock_irq);
	cov_vco_base: cover property (!base_ff ##1 base_ff);
	cov_manual_track: cover property (!ctrl_ff.auto_bw && track_ff);

endmodule

/* testbench/pbmc_tb_top.sv */
// Self-checking testbench for the loop bandwidth control block.
`timescale 1ns/1ps
module pbmc_tb_top;
	import pbmc_pkg::*;

	logic           ref_clk = 1'b0;
	logic           rst = 1'b1;
	logic           wb_cyc = 1'b0;
	logic           wb_stb = 1'b0;
	logic           wb_we = 1'b0;
	logic [7:0]     wb_adr = 8'h00;
	logic [3:0]     wb_sel = 4'h0;
	logic [31:0]    wb_dat_w = 32'h0;
	logic [31:0]    wb_dat_r;
	logic           wb_ack;
	logic           vco_clock = 1'b0;
	logic           vco_run = 1'b0;
	logic [1:0]     vco_ph = 2'h0;
	logic           loop_power_on;
	logic           filter_track_flag;
	logic           base_clock_select;
	logic [1:0]     prescale_exp;
	logic [1:0]     range_exp;
	logic [L_W-1:0] range_mult;
	logic [N_W-1:0] fb_mult;
	logic [R_W-1:0] ref_div;
	logic           locked;
	logic           lock_irq;
	logic           bus_clk_en;
	int             errors = 0;
	int             check_count = 0;
	int             irq_cnt = 0;
	logic [31:0]    rd;

	// The crystal clock runs at 10 MHz.
	always #50 ref_clk = ~ref_clk;

	// Feedback clock of eight crystal cycles; stands still low while stopped.
	always @(posedge ref_clk) begin
		vco_ph <= vco_ph + 2'h1;
		if (!vco_run) begin
			vco_clock <= 1'b0;
		end else if (vco_ph == 2'h3) begin
			vco_clock <= ~vco_clock;
		end
	end

	// Interrupt pulses are counted as they stand, one cycle each.
	always @(posedge ref_clk) begin
		if (lock_irq === 1'b1)
			irq_cnt <= irq_cnt + 1;
	end

	pbmc_top u_dut (
		.ref_clk           (ref_clk),
		.rst               (rst),
		.wb_cyc            (wb_cyc),
		.wb_stb            (wb_stb),
		.wb_we             (wb_we),
		.wb_adr            (wb_adr),
		.wb_sel            (wb_sel),
		.wb_dat_w          (wb_dat_w),
		.wb_dat_r          (wb_dat_r),
		.wb_ack            (wb_ack),
		.vco_clock         (vco_clock),
		.loop_power_on     (loop_power_on),
		.filter_track_flag (filter_track_flag),
		.base_clock_select (base_clock_select),
		.prescale_exp      (prescale_exp),
		.range_exp         (range_exp),
		.range_mult        (range_mult),
		.fb_mult           (fb_mult),
		.ref_div           (ref_div),
		.locked            (locked),
		.lock_irq          (lock_irq),
		.bus_clk_en        (bus_clk_en)
	);

	task automatic complete_run();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, exp, input string m);
		check_word({31'h0, got}, {31'h0, exp}, m);
	endtask

	// One classic cycle; the request holds until ack is sampled high.
	task automatic wb_xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20)
			check_bit(1'b0, 1'b1, "ack timeout");
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, q);
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic rdw(input logic [7:0] a, output logic [31:0] q);
		wb_xfer(1'b0, a, 32'h0, q);
	endtask

	// Waits, bounded, for the lock flag to reach a level.
	task automatic wait_lock(input logic v);
		int n;
		for (n = 0; n < 1500 && locked !== v; n++)
			@(posedge ref_clk);
	endtask

	// Counts bus clock enables over a span of crystal cycles.
	task automatic count_en(input int span, output int c);
		c = 0;
		repeat (span) begin
			@(posedge ref_clk);
			if (bus_clk_en === 1'b1)
				c++;
		end
	endtask

	task automatic test_regs();
		int c;
		rdw(OFS_FBMUL, rd);
		check_word(rd, 32'h001, "fbmul reset");
		rdw(OFS_VRANGE, rd);
		check_word(rd, 32'h080, "vrange reset");
		rdw(8'h20, rd);
		check_word(rd, 32'h0, "unmapped read");
		wr(OFS_FBMUL, 32'h12C);
		check_word({20'h0, fb_mult}, 32'h12C, "fb_mult");
		wr(OFS_FBMUL, 32'h0);
		check_word({20'h0, fb_mult}, 32'h1, "fb zero");
		wr(OFS_REFDIV, 32'h0);
		check_word({28'h0, ref_div}, 32'h1, "refdiv zero");
		wr(OFS_CTRL, 32'h04);
		check_bit(base_clock_select, 1'b0, "base while off");
		count_en(40, c);
		check_word(c, 32'd10, "crystal bus rate");
		check_word({24'h0, range_mult}, 32'h80, "range_mult reset");
		wr(OFS_CTRL, 32'h220);
		check_word({30'h0, range_exp}, 32'h2, "range_exp");
		check_word({30'h0, prescale_exp}, 32'h1, "prescale_exp");
		rdw(OFS_CTRL, rd);
		check_word(rd, 32'h220, "ctrl readback");
		$display("test_regs done");
	endtask

	task automatic test_manual();
		int c;
		wr(OFS_REFDIV, 32'h8);
		vco_run <= 1'b1;
		wr(OFS_CTRL, 32'h0A);
		repeat (400) @(posedge ref_clk);
		check_bit(locked, 1'b0, "manual lock");
		check_word(irq_cnt, 32'd0, "manual irq");
		check_bit(filter_track_flag, 1'b0, "manual acquire");
		wr(OFS_CTRL, 32'h1A);
		check_bit(filter_track_flag, 1'b1, "manual track");
		wr(OFS_CTRL, 32'h1E);
		check_bit(base_clock_select, 1'b1, "vco selected");
		rdw(OFS_STATUS, rd);
		check_word(rd, 32'h6, "status manual");
		count_en(320, c);
		check_bit(c >= 9 && c <= 10, 1'b1, "vco bus rate");
		wr(OFS_CTRL, 32'h08);
		check_bit(loop_power_on, 1'b1, "power off refused");
		check_bit(base_clock_select, 1'b0, "vco deselected");
		wr(OFS_CTRL, 32'h0A);
		wr(OFS_CTRL, 32'h00);
		check_bit(loop_power_on, 1'b0, "loop off");
		$display("test_manual done");
	endtask

	task automatic test_auto();
		wr(OFS_CTRL, 32'h0B);
		wr(OFS_CTRL, 32'h1B);
		check_bit(filter_track_flag, 1'b0, "auto write ignored");
		wait_lock(1'b1);
		// The interrupt counter settles one edge after the flag is seen.
		@(posedge ref_clk);
		check_bit(locked, 1'b1, "auto lock");
		check_bit(filter_track_flag, 1'b1, "auto track");
		check_word(irq_cnt, 32'd1, "irq on lock");
		rdw(OFS_STATUS, rd);
		check_word(rd, 32'h3, "status auto");
		wr(OFS_CTRL, 32'h0F);
		check_bit(base_clock_select, 1'b1, "vco after lock");
		vco_run <= 1'b0;
		wait_lock(1'b0);
		// A partly counted window may keep tracking; wait one full window.
		repeat (130) @(posedge ref_clk);
		check_bit(locked, 1'b0, "lost lock");
		check_bit(filter_track_flag, 1'b0, "back to acquire");
		check_word(irq_cnt, 32'd2, "irq on unlock");
		$display("test_auto done");
	endtask

	// Watchdog: the tests take about 1300 cycles, at most about 4000.
	initial begin
		#3000000;
		errors++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		test_regs();
		test_manual();
		test_auto();
		complete_run();
	end
endmodule
